/* File: logic/hdr_pkg.sv */
// How it works
// - Analog comparators give one at or above threshold, zero at rest.
// - Captured channel state is held in flops until the next rising edge.
// - A pulse held over many cycles is caught by its rising edge and counts once.
// - Timestamp counts every clock and is cleared by the counter reset input.
// - Each stored event word carries the timestamp as its event identifier.
// - Timestamp advances at the system clock rate.
// - Timestamp and channel states enter the pipeline as one word per clock.
// - Word leaving the pipeline with second-level accept goes to FIFO, else dropped.
// - Readout pulls words from the FIFO and sends them off chip.
// - Only words passing the multiplicity check are marked valid in the pipeline.
// - The multiplicity result is driven on an output pin.
// - Output link is push only with no return path.
// - Output link sends one bit per clock.
// - All logic runs on one clock.
// - Inject strobe fires charge injection when enabled over control.
// - Settings are written and read back over the control bus.
// - Each channel hit is ANDed with its mask bit.
// - Threshold DAC code is loaded over the control bus.
// - Logic is plain synchronous flops with short paths, save the trigger output pulse gated with the clock.
// - Sixty-four channels, each with its own state and mask bit.
// - Coincidence select clear fires on one hit, set needs two or more.
// - Window select clear uses one cycle, set uses eight cycles.
// - Trigger output pulse lasts half a clock period, rising at the edge.
package hdr_pkg;
   localparam int NCH = 64;
   localparam int TS_W = 16;
   localparam int WORD_W = 80;
   localparam int PIPE_DEPTH = 8;
   localparam int WIN_LEN = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam int FRAME_LEN = 81;
   localparam int BITCNT_W = 7;
   localparam int THR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MASK_LO = 8'h04;
   localparam logic [7:0] REG_MASK_HI = 8'h08;
   localparam logic [7:0] REG_THRESH = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_TSTAMP = 8'h14;
   localparam int CTRL_COINC_BIT = 0;
   localparam int CTRL_WIN_BIT = 1;
   localparam int CTRL_INJ_BIT = 2;
   localparam int ST_OVF_BIT = 0;
   localparam int ST_EMPTY_BIT = 1;
   localparam int ST_FULL_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
   localparam logic [THR_W-1:0] THR_RST = 8'h80;
   typedef enum logic [1:0] {
      SER_IDLE = 2'b01,
      SER_SEND = 2'b10
   } hdr_ser_state_t;
   function automatic logic [31:0] sel_merge(input logic [31:0] old,
         input logic [31:0] wr, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wr[b*8 +: 8];
         end
      end
      return r;
   endfunction : sel_merge
   function automatic logic two_or_more(input logic [NCH-1:0] v);
      return |(v & (v - 64'h0000_0000_0000_0001));
   endfunction : two_or_more
endpackage : hdr_pkg

/* File: logic/hdr_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module hdr_fifo
   import hdr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WORD_W-1:0] wr_data_i,
   // Drain side
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WORD_W-1:0] rd_data_o,
   // State
   output logic empty_o,
   output logic full_o
);
   logic [WORD_W-1:0] mem [FIFO_DEPTH];
   logic [FIFO_AW:0] wptr;
   logic [FIFO_AW:0] rptr;
   logic do_wr;
   logic do_rd;
   assign empty_o = (wptr == rptr);
   assign full_o = (wptr[FIFO_AW] != rptr[FIFO_AW]) &&
                   (wptr[FIFO_AW-1:0] == rptr[FIFO_AW-1:0]);
   assign wr_ready_o = !full_o;
   assign rd_valid_o = !empty_o;
   assign rd_data_o = mem[rptr[FIFO_AW-1:0]];
   assign do_wr = wr_valid_i && !full_o;
   assign do_rd = rd_ready_i && !empty_o;
   // A refused write leaves the stored words untouched.
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wptr[FIFO_AW-1:0]] <= wr_data_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (do_wr) begin
            wptr <= wptr + 5'h1;
         end
         if (do_rd) begin
            rptr <= rptr + 5'h1;
         end
      end
   end
endmodule : hdr_fifo
`default_nettype wire

/* File: logic/hdr_serializer.sv */
`timescale 1ns/10ps
`default_nettype none
module hdr_serializer
   import hdr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Word source
   input wire logic word_valid_i,
   output logic word_ready_o,
   input wire logic [WORD_W-1:0] word_i,
   // Serial link
   output logic ser_data_o,
   output logic busy_o
);
   hdr_ser_state_t state;
   logic [FRAME_LEN-1:0] shreg;
   logic [BITCNT_W-1:0] cnt;
   assign word_ready_o = (state == SER_IDLE);
   assign busy_o = (state == SER_SEND);
   // Frame is a start bit of one followed by the word, most significant first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= SER_IDLE;
         shreg <= '0;
         cnt <= '0;
         ser_data_o <= 1'b0;
      end else begin
         case (state)
            SER_IDLE: begin
               ser_data_o <= 1'b0;
               cnt <= '0;
               if (word_valid_i) begin
                  shreg <= {1'b1, word_i};
                  state <= SER_SEND;
               end
            end
            SER_SEND: begin
               ser_data_o <= shreg[FRAME_LEN-1];
               shreg <= {shreg[FRAME_LEN-2:0], 1'b0};
               cnt <= cnt + 7'h01;
               if (cnt == BITCNT_W'(FRAME_LEN - 1)) begin
                  state <= SER_IDLE;
               end
            end
            default: begin
               state <= SER_IDLE;
               ser_data_o <= 1'b0;
            end
         endcase
      end
   end
endmodule : hdr_serializer
`default_nettype wire

/* File: logic/hdr_readout_top.sv */
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hdr_readout_top
   import hdr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Comparator outputs and threshold code
   input wire logic [NCH-1:0] disc_i,
   output logic [THR_W-1:0] threshold_code_o,
   // Timing inputs and injection
   input wire logic counter_reset_i,
   input wire logic inject_strobe_i,
   output logic inject_pulse_o,
   // Trigger
   output logic local_trigger_accept_o,
   output logic trigger_output_pulse_o,
   input wire logic l1_accept_i,
   // Serial output link
   output logic ser_data_o
);

   // Control bus state.
   logic ack_q;
   logic bus_req;
   logic bus_wr;
   logic [31:0] rd_mux;
   logic [2:0] ctrl;
   logic [31:0] mask_lo;
   logic [31:0] mask_hi;
   logic [THR_W-1:0] thresh;
   logic overflow;
   logic [31:0] next_ctrl_word;
   logic [31:0] next_thr_word;

   // Pin synchronisers.
   logic [NCH-1:0] disc_s1;
   logic [NCH-1:0] disc_s2;
   logic [NCH-1:0] disc_s3;
   logic crst_s1;
   logic crst_s2;
   logic inj_s1;
   logic inj_s2;
   logic inj_s3;
   logic l1_s1;
   logic l1_s2;

   // Hit capture and trigger.
   logic [NCH-1:0] mask;
   logic [NCH-1:0] hit_q;
   logic [NCH-1:0] hist [WIN_LEN-1];
   logic [NCH-1:0] hist_or;
   logic [NCH-1:0] win_vec;
   logic trig_now;
   logic trig_q;
   logic [TS_W-1:0] tstamp;

   // Pipeline and readout.
   logic pipe_vld [PIPE_DEPTH];
   logic [WORD_W-1:0] pipe_dat [PIPE_DEPTH];
   logic fifo_wr;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [WORD_W-1:0] fifo_rd_data;
   logic fifo_empty;
   logic fifo_full;
   logic ser_busy;

   //------------------------------------------------------------
   // Wishbone classic slave, one wait state on every access.
   //------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i;
   // Writes land on the edge at which the master sees ack high.
   assign bus_wr = bus_req && wb_we_i && ack_q;
   assign wb_ack_o = ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req && !ack_q;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         REG_CTRL: begin
            rd_mux[2:0] = ctrl;
         end
         REG_MASK_LO: begin
            rd_mux = mask_lo;
         end
         REG_MASK_HI: begin
            rd_mux = mask_hi;
         end
         REG_THRESH: begin
            rd_mux[THR_W-1:0] = thresh;
         end
         REG_STATUS: begin
            rd_mux[ST_OVF_BIT] = overflow;
            rd_mux[ST_EMPTY_BIT] = fifo_empty;
            rd_mux[ST_FULL_BIT] = fifo_full;
            rd_mux[ST_BUSY_BIT] = ser_busy;
         end
         REG_TSTAMP: begin
            rd_mux[TS_W-1:0] = tstamp;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req && !ack_q && !wb_we_i) begin
         wb_dat_o <= rd_mux;
      end
   end

   assign next_ctrl_word = sel_merge({29'h0, ctrl}, wb_dat_i, wb_sel_i);
   assign next_thr_word = sel_merge({24'h00_0000, thresh}, wb_dat_i,
                                    wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
      end else if (bus_wr && wb_adr_i == REG_CTRL) begin
         ctrl <= next_ctrl_word[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_lo <= MASK_RST;
         mask_hi <= MASK_RST;
      end else if (bus_wr) begin
         if (wb_adr_i == REG_MASK_LO) begin
            mask_lo <= sel_merge(mask_lo, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == REG_MASK_HI) begin
            mask_hi <= sel_merge(mask_hi, wb_dat_i, wb_sel_i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thresh <= THR_RST;
      end else if (bus_wr && wb_adr_i == REG_THRESH) begin
         thresh <= next_thr_word[THR_W-1:0];
      end
   end

   // The DAC code comes straight from its register, so it never glitches.
   assign threshold_code_o = thresh;

   // Overflow is write-one-to-clear; a new overflow in the same cycle wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow <= 1'b0;
      end else if (fifo_wr && !fifo_wr_ready) begin
         overflow <= 1'b1;
      end else if (bus_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] &&
                   wb_dat_i[ST_OVF_BIT]) begin
         overflow <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Pin synchronisers, two flops before any logic.
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disc_s1 <= '0;
         disc_s2 <= '0;
         disc_s3 <= '0;
      end else begin
         disc_s1 <= disc_i;
         disc_s2 <= disc_s1;
         disc_s3 <= disc_s2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crst_s1 <= 1'b0;
         crst_s2 <= 1'b0;
         inj_s1 <= 1'b0;
         inj_s2 <= 1'b0;
         inj_s3 <= 1'b0;
         l1_s1 <= 1'b0;
         l1_s2 <= 1'b0;
      end else begin
         crst_s1 <= counter_reset_i;
         crst_s2 <= crst_s1;
         inj_s1 <= inject_strobe_i;
         inj_s2 <= inj_s1;
         inj_s3 <= inj_s2;
         l1_s1 <= l1_accept_i;
         l1_s2 <= l1_s1;
      end
   end

   //------------------------------------------------------------
   // Hit capture. A comparator that stays high over many cycles
   // would otherwise flood the trigger, so only its rising edge
   // counts. Pulses narrower than a clock period must be widened
   // by the analog stretcher before they reach the pins.
   //------------------------------------------------------------
   assign mask = {mask_hi, mask_lo};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_q <= '0;
      end else begin
         hit_q <= disc_s2 & ~disc_s3 & mask;
      end
   end

   // History of earlier hit vectors for the long window.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < WIN_LEN - 1; i++) begin
            hist[i] <= '0;
         end
      end else begin
         hist[0] <= hit_q;
         for (int i = 1; i < WIN_LEN - 1; i++) begin
            hist[i] <= hist[i-1];
         end
      end
   end

   always_comb begin
      hist_or = '0;
      for (int i = 0; i < WIN_LEN - 1; i++) begin
         hist_or = hist_or | hist[i];
      end
   end

   // Window of one or eight cycles, then the multiplicity test.
   assign win_vec = ctrl[CTRL_WIN_BIT] ? (hit_q | hist_or) : hit_q;
   assign trig_now = ctrl[CTRL_COINC_BIT] ? two_or_more(win_vec)
                                          : |win_vec;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= trig_now;
      end
   end

   assign local_trigger_accept_o = trig_q;
   // Gating with the clock gives a half-period pulse that rises on the
   // edge; the receiver must use only its rising edge.
   assign trigger_output_pulse_o = trig_q & clk_i;

   //------------------------------------------------------------
   // Timestamp, one count per clock, cleared by counter reset.
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tstamp <= '0;
      end else if (crst_s2) begin
         tstamp <= '0;
      end else begin
         tstamp <= tstamp + 16'h0001;
      end
   end

   //------------------------------------------------------------
   // Charge injection on a synchronised strobe edge when enabled.
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inject_pulse_o <= 1'b0;
      end else begin
         inject_pulse_o <= ctrl[CTRL_INJ_BIT] && inj_s2 && !inj_s3;
      end
   end

   //------------------------------------------------------------
   // Event pipeline: a word enters every clock, marked valid only when the trigger fires.
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_vld[i] <= 1'b0;
            pipe_dat[i] <= '0;
         end
      end else begin
         pipe_vld[0] <= trig_now;
         pipe_dat[0] <= {tstamp, win_vec};
         for (int i = 1; i < PIPE_DEPTH; i++) begin
            pipe_vld[i] <= pipe_vld[i-1];
            pipe_dat[i] <= pipe_dat[i-1];
         end
      end
   end

   // Without accept the word simply falls off the end of the pipeline.
   assign fifo_wr = pipe_vld[PIPE_DEPTH-1] && l1_s2;

   hdr_fifo u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_valid_i(fifo_wr),
      .wr_ready_o(fifo_wr_ready),
      .wr_data_i(pipe_dat[PIPE_DEPTH-1]),
      .rd_valid_o(fifo_rd_valid),
      .rd_ready_i(fifo_rd_ready),
      .rd_data_o(fifo_rd_data),
      .empty_o(fifo_empty),
      .full_o(fifo_full)
   );

   // Push only: the link has no return path, so nothing stalls the sender.
   hdr_serializer u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .word_valid_i(fifo_rd_valid),
      .word_ready_o(fifo_rd_ready),
      .word_i(fifo_rd_data),
      .ser_data_o(ser_data_o),
      .busy_o(ser_busy)
   );

endmodule : hdr_readout_top
`default_nettype wire

/* File: dv/hdr_readout_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module hdr_readout_asserts
   import hdr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Front end and outputs
   input wire logic [NCH-1:0] disc_i,
   input wire logic [THR_W-1:0] threshold_code_o,
   input wire logic inject_pulse_o,
   input wire logic local_trigger_accept_o,
   input wire logic ser_data_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [NCH-1:0] disc_q;
   logic [7:0] quiet;
   logic [6:0] fpos;
   // Cycles since any comparator rose; a trigger long after the last rise is spurious.
   always_ff @(posedge clk_i) begin
      disc_q <= disc_i;
      if (rst_i || |(disc_i & ~disc_q)) begin
         quiet <= 8'h00;
      end else if (quiet != 8'hFF) begin
         quiet <= quiet + 8'h01;
      end
   end
   // Bit position in the current serial frame, start bit at zero.
   always_ff @(posedge clk_i) begin
      if (rst_i || fpos == 7'h51) begin
         fpos <= 7'h00;
      end else if (fpos == 7'h00) begin
         fpos <= {6'h00, ser_data_o};
      end else begin
         fpos <= fpos + 7'h01;
      end
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_thr_wr;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == REG_THRESH && wb_sel_i[0];
   endsequence
   a_bus_answer: assert property (s_req |=> wb_ack_o)
      else $error("bus ack not one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   a_thresh_load: assert property (s_thr_wr |=> threshold_code_o == $past(wb_dat_i[7:0]))
      else $error("threshold code not loaded");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h05
      |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_trig_needs_hit: assert property (quiet > 8'h0F |-> !local_trigger_accept_o)
      else $error("trigger without recent hit");
   a_inject_single: assert property (inject_pulse_o |=> !inject_pulse_o)
      else $error("inject pulse too long");
   a_frame_gap: assert property (fpos == 7'h51 |-> !ser_data_o)
      else $error("no idle bit after frame");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !ser_data_o
      && !local_trigger_accept_o && !inject_pulse_o && threshold_code_o == THR_RST)
      else $error("outputs not at reset values");
endmodule : hdr_readout_asserts
bind hdr_readout_top hdr_readout_asserts hdr_readout_asserts_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .disc_i(disc_i),
   .threshold_code_o(threshold_code_o), .inject_pulse_o(inject_pulse_o),
   .local_trigger_accept_o(local_trigger_accept_o), .ser_data_o(ser_data_o));
`default_nettype wire

/* File: dv/hdr_daq_model.sv */
`timescale 1ns/10ps
`default_nettype none
module hdr_daq_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Trigger side
   input wire logic trig_i,
   input wire logic accept_en_i,
   output logic l1_accept_o,
   // Data link
   input wire logic ser_i,
   output logic [79:0] frame_o,
   output logic [15:0] frame_cnt_o
);
   logic [4:0] trig_sr;
   logic [79:0] shift;
   logic [6:0] pos;
   // Accept spans three cycles around the pipe end, so it lands however the trigger aligns.
   always_ff @(posedge clk_i) begin
      trig_sr <= rst_i ? 5'h00 : {trig_sr[3:0], trig_i};
      l1_accept_o <= !rst_i && accept_en_i && |trig_sr[4:2];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos <= 7'h00;
         frame_cnt_o <= 16'h0000;
      end else if (pos == 7'h00) begin
         pos <= {6'h00, ser_i};
      end else begin
         shift <= {shift[78:0], ser_i};
         pos <= (pos == 7'h50) ? 7'h00 : pos + 7'h01;
         if (pos == 7'h50) begin
            frame_o <= {shift[78:0], ser_i};
            frame_cnt_o <= frame_cnt_o + 16'h0001;
         end
      end
   end
endmodule : hdr_daq_model
`default_nettype wire

/* File: dv/hdr_readout_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module hdr_readout_top_test;
   import hdr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, counter_reset_i, inject_strobe_i;
   logic inject_pulse_o, local_trigger_accept_o, trigger_output_pulse_o, l1_accept_i;
   logic ser_data_o, accept_en;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [NCH-1:0] disc_i;
   logic [THR_W-1:0] threshold_code_o;
   logic [79:0] frame;
   logic [15:0] fcnt, t1;
   int n_mismatch = 0, n_tests = 0, trig_n = 0, inj_n = 0;
   always #50 clk_i = ~clk_i;
   hdr_readout_top hdr_readout_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .disc_i(disc_i),
      .threshold_code_o(threshold_code_o), .counter_reset_i(counter_reset_i),
      .inject_strobe_i(inject_strobe_i), .inject_pulse_o(inject_pulse_o),
      .local_trigger_accept_o(local_trigger_accept_o), .l1_accept_i(l1_accept_i),
      .trigger_output_pulse_o(trigger_output_pulse_o), .ser_data_o(ser_data_o));
   hdr_daq_model hdr_daq_model_i (.clk_i(clk_i), .rst_i(rst_i),
      .trig_i(local_trigger_accept_o), .accept_en_i(accept_en), .l1_accept_o(l1_accept_i),
      .ser_i(ser_data_o), .frame_o(frame), .frame_cnt_o(fcnt));
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic timeout(input string what);
      n_mismatch++;
      $display("Error %s expected done seen timeout", what);
      complete_run();
   endtask : timeout
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
         input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      if (wb_ack_o !== 1'b1) begin
         timeout("bus ack");
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, 4'hF, dat);
   endtask : wr
   task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 4'hF, 32'h0000_0000);
      chk(what, exp, rd);
   endtask : rdchk
   task automatic hit(input logic [NCH-1:0] v, input int len);
      @(posedge clk_i);
      disc_i <= v;
      tick(len);
      disc_i <= '0;
   endtask : hit
   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (fcnt < n && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      if (fcnt < n) begin
         timeout("frame");
      end
   endtask : wait_frames
   // A held comparator counts once, so each hit stays up several cycles.
   task automatic t_hits();
      int b;
      accept_en <= 1'b1;
      b = trig_n;
      hit(64'h0000_0000_0000_0020, 5);
      wait_frames(fcnt + 1);
      chk("single trigger", 1, trig_n - b);
      chk("single word", 64'h0000_0000_0000_0020, frame[63:0]);
      wr(REG_MASK_LO, 32'hFFFF_FFDF);
      wr(REG_MASK_HI, 32'hFFFF_FFFE);
      b = trig_n;
      hit(64'h0000_0001_0000_0020, 3);
      tick(12);
      chk("masked trigger", 0, trig_n - b);
      wr(REG_MASK_LO, 32'hFFFF_FFFF);
      wr(REG_MASK_HI, 32'hFFFF_FFFF);
      wr(REG_CTRL, 32'h0000_0001);
      b = trig_n;
      hit(64'h0000_0000_0000_0002, 3);
      tick(12);
      chk("coinc single", 0, trig_n - b);
      hit(64'h0000_0100_0000_0002, 3);
      wait_frames(fcnt + 1);
      chk("coinc pair", 1, trig_n - b);
      chk("pair word", 64'h0000_0100_0000_0002, frame[63:0]);
   endtask : t_hits
   task automatic t_window();
      int b, f;
      accept_en <= 1'b0;
      f = fcnt;
      wr(REG_CTRL, 32'h0000_0002);
      b = trig_n;
      hit(64'h0000_0000_0000_0200, 3);
      tick(16);
      chk("long window", 8, trig_n - b);
      wr(REG_CTRL, 32'h0000_0003);
      b = trig_n;
      @(posedge clk_i);
      disc_i <= 64'h0000_0000_0000_0008;
      tick(4);
      disc_i <= 64'h0004_0000_0000_0008;
      hit(64'h0000_0000_0000_0000, 16);
      chk("window pair", 4, trig_n - b);
      tick(150);
      chk("rejected frames", f, fcnt);
   endtask : t_window
   task automatic t_overflow();
      int k;
      accept_en <= 1'b1;
      wr(REG_CTRL, 32'h0000_0002);
      for (int i = 0; i < 4; i++) begin
         hit(64'h0000_0000_0000_0001 << (i * 4), 2);
         tick(8);
      end
      tick(30);
      wb(1'b0, REG_STATUS, 4'hF, 32'h0000_0000);
      chk("overflow set", 1, rd[ST_OVF_BIT]);
      wr(REG_STATUS, 32'h0000_0001);
      wb(1'b0, REG_STATUS, 4'hF, 32'h0000_0000);
      chk("overflow clear", 0, rd[ST_OVF_BIT]);
      wr(REG_CTRL, 32'h0000_0000);
      k = 0;
      while (rd !== 32'h0000_0002 && k < 40) begin
         tick(100);
         wb(1'b0, REG_STATUS, 4'hF, 32'h0000_0000);
         k++;
      end
      chk("drained status", 32'h0000_0002, rd);
   endtask : t_overflow
   task automatic t_inject_ts();
      int b;
      for (int e = 1; e >= 0; e--) begin
         wr(REG_CTRL, e ? 32'h0000_0004 : 32'h0000_0000);
         b = inj_n;
         @(posedge clk_i);
         inject_strobe_i <= 1'b1;
         tick(4);
         inject_strobe_i <= 1'b0;
         tick(8);
         chk("inject pulses", e, inj_n - b);
      end
      counter_reset_i <= 1'b1;
      tick(5);
      rdchk("stamp held", REG_TSTAMP, 32'h0000_0000);
      counter_reset_i <= 1'b0;
      tick(10);
      wb(1'b0, REG_TSTAMP, 4'hF, 32'h0000_0000);
      chk("stamp runs", 1, rd != 32'h0000_0000);
      b = fcnt;
      hit(64'h0000_0000_0000_0004, 2);
      tick(18);
      hit(64'h0000_0000_0000_0008, 2);
      wait_frames(b + 1);
      t1 = frame[79:64];
      wait_frames(b + 2);
      chk("stamp step", 16'h0015, 16'(frame[79:64] - t1));
   endtask : t_inject_ts
   always @(posedge clk_i) begin
      if (local_trigger_accept_o === 1'b1) begin
         trig_n <= trig_n + 1;
      end
      if (inject_pulse_o === 1'b1) begin
         inj_n <= inj_n + 1;
      end
      #1;
      chk("trigger pulse high half", local_trigger_accept_o, trigger_output_pulse_o);
   end
   always @(negedge clk_i) begin
      #1 chk("trigger pulse low half", 0, trigger_output_pulse_o);
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, counter_reset_i, inject_strobe_i} = 6'h20;
      {wb_adr_i, wb_sel_i, wb_dat_i, disc_i, accept_en} = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("ctrl reset", REG_CTRL, 32'h0000_0000);
      rdchk("mask lo reset", REG_MASK_LO, 32'hFFFF_FFFF);
      rdchk("mask hi reset", REG_MASK_HI, 32'hFFFF_FFFF);
      rdchk("thresh reset", REG_THRESH, 32'h0000_0080);
      rdchk("status reset", REG_STATUS, 32'h0000_0002);
      rdchk("unmapped read", 8'h40, 32'h0000_0000);
      wr(REG_THRESH, 32'h0000_003C);
      wb(1'b1, REG_MASK_LO, 4'h1, 32'h0000_0000);
      chk("threshold code", 8'h3C, threshold_code_o);
      rdchk("mask byte write", REG_MASK_LO, 32'hFFFF_FF00);
      wr(REG_MASK_LO, 32'hFFFF_FFFF);
      t_hits();
      t_window();
      t_overflow();
      t_inject_ts();
      complete_run();
   end
   initial begin
      tick(100000);
      timeout("run");
   end
endmodule : hdr_readout_top_test
`default_nettype wire
